// ---- hw/cri_pkg.sv ----
// Package of reset values, soft-init bit positions and register offsets for the init-state block
package cri_pkg;
  // ---------------------------------------------------------------
  // Architectural reset values
  // ---------------------------------------------------------------
  localparam logic [31:0] CTRL_RST      = 32'h60000010;
  localparam int          CTRL_CD_BIT   = 30;
  localparam int          CTRL_NW_BIT   = 29;
  localparam int          CTRL_ONE_BIT  = 4;
  localparam logic [31:0] FLAGS_RST     = 32'h00000002;
  localparam logic [31:0] IP_RST        = 32'h0000fff0;
  localparam logic [15:0] CS_SEL_RST    = 16'hf000;
  localparam logic [31:0] CS_BASE_RST   = 32'hffff0000;
  localparam logic [15:0] SEG_LIMIT_RST = 16'hffff;
  localparam logic [15:0] DS_SEL_RST    = 16'h0000;
  localparam logic [31:0] DS_BASE_RST   = 32'h00000000;
  localparam logic [3:0]  SEG_AR_RST    = 4'h7;        // Present, R/W, accessed
  localparam logic [15:0] FPU_CW_RST    = 16'h0040;
  localparam logic [15:0] FPU_CW_FINIT  = 16'h037f;
  localparam logic [15:0] FPU_SW_CLR    = 16'h0000;
  localparam logic [15:0] FPU_TAG_RST   = 16'h5555;
  localparam logic [15:0] FPU_TAG_FINIT = 16'hffff;
  localparam logic [31:0] VCSR_RST      = 32'h00001f80;
  localparam int          SELFTEST_CYC  = 16;

  // ---------------------------------------------------------------
  // APB register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_FLAGS  = 8'h04;
  localparam logic [7:0] A_IP     = 8'h08;
  localparam logic [7:0] A_ACC    = 8'h0c;
  localparam logic [7:0] A_CSSEL  = 8'h10;
  localparam logic [7:0] A_CSBASE = 8'h14;
  localparam logic [7:0] A_FPUCW  = 8'h18;
  localparam logic [7:0] A_FPUSW  = 8'h1c;
  localparam logic [7:0] A_FPUTAG = 8'h20;
  localparam logic [7:0] A_FPUOP  = 8'h24;
  localparam logic [7:0] A_VCSR   = 8'h28;
  localparam logic [7:0] A_TSC    = 8'h2c;
  localparam logic [7:0] A_PERF   = 8'h30;
  localparam logic [7:0] A_EVSEL  = 8'h34;
  localparam logic [7:0] A_CFG    = 8'h38;    // Cache valid, range enable, irq ctrl enable
  localparam logic [7:0] A_STAT   = 8'h3c;    // Self-test fail in bit 31, sequencer state in bits 3:0
  localparam logic [7:0] A_FPUREG = 8'h40;    // Index in bits 5:3 selects FP reg
  localparam logic [7:0] A_PKREG  = 8'h80;    // Packed regs, low word only
  localparam logic [7:0] A_XVREG  = 8'hc0;    // Extra vector regs, low word only

  typedef enum logic [3:0]
  {
    ST_RESET = 4'h1,
    ST_TEST  = 4'h2,
    ST_SOFT  = 4'h4,
    ST_RUN   = 4'h8
  } cri_state_e;
endpackage

// ---- hw/cri_regmem.sv ----
// Small register array with cleared-on-reset entries and registered read data
`timescale 1ns/1ns
module cri_regmem #(
  parameter int DEPTH = 8,
  parameter int WIDTH = 64
) (
  input  wire logic                     clk,
  input  wire logic                     clr,
  input  wire logic                     we,
  input  wire logic [$clog2(DEPTH)-1:0] waddr,
  input  wire logic [WIDTH-1:0]         wdata,
  input  wire logic [$clog2(DEPTH)-1:0] raddr,
  output logic      [WIDTH-1:0]         rdata
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  // One entry per slot; clear wins over a write so no stale value survives
  for (genvar i = 0; i < DEPTH; i++)
  begin : g_ent
    always_ff @(posedge clk)
    begin
      if (clr)
        mem_q[i] <= '0;
      else if (we && waddr == AW'(i))
        mem_q[i] <= wdata;
    end
  end

  // Read port is registered
  always_ff @(posedge clk)
  begin
    if (clr)
      rdata <= '0;
    else
      rdata <= mem_q[raddr];
  end
endmodule

// ---- hw/cri_init_state.sv ----
// Architectural state initializer: hardware reset, soft init and FP initialize
//
// The APB register port and the register addresses were decided locally.
`timescale 1ns/1ns

// Overview of operation
// RULE1: Hardware reset loads control register 60000010H: real mode, paging off.
// RULE2: Flags word reads 00000002H after reset; top ten bits are don't-care.
// RULE3: Soft init keeps cache-disable and write-through-suppress, sets bit 4, clears rest.
// RULE4: Code segment resets to selector F000H, base FFFF0000H, limit FFFFH, present/RW/accessed.
// RULE5: Data and stack segments reset to selector 0, base 0, limit FFFFH.
// RULE6: Accumulator holds zero after self-test only if all tests passed.
// RULE7: Self-test never runs on soft init, only on hardware reset.
// RULE8: FP data registers clear to +0.0 on reset; FP initialize leaves them.
// RULE9: FP control word is 0040H on reset, 037FH on FP initialize.
// RULE10: FP status, opcode and selector fields clear on reset and FP initialize.
// RULE11: FP tag word is 5555H on reset, FFFFH on FP initialize.
// RULE12: Soft init leaves all FP and packed-integer state untouched.
// RULE13: Packed-integer registers clear on reset only; unchanged by soft init and FP init.
// RULE14: Vector control/status resets to 1F80H and survives soft init.
// RULE15: Time-stamp, performance and event-select counters clear on reset only.
// RULE16: Reset invalidates caches and translation buffers; soft init leaves them.
// RULE17: Memory-type range mechanisms come up disabled and survive soft init.
// RULE18: Local interrupt controller comes up enabled; soft init leaves it.
// RULE19: Extra general registers zero after reset; extra vector regs clear on reset only.
// RULE20: Separate reset and soft init inputs, each applying its own value set.
// RULE21: First fetch after reset or soft init is code base plus reset pointer.
module cri_init_state #(
  parameter bit          SELFTEST_EN = 1'b1,
  parameter bit          EXT64_EN    = 1'b1,
  parameter logic [31:0] ID_SIG      = 32'h0000_0a5a   // Arbitrary identity value
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        softInit,
  input  wire logic        fpuInit,
  input  wire logic        selfTestFail,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             fetchReq,
  output logic      [31:0] fetchAddr,
  output logic             cacheValid,
  output logic             rangeEnable,
  output logic             irqCtrlEnable,
  output logic             extRegsZero
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  cri_pkg::cri_state_e state_q;
  logic [31:0] ctrl_q;
  logic [31:0] flags_q;
  logic [31:0] ip_q;
  logic [31:0] acc_q;
  logic [15:0] csSel_q;
  logic [31:0] csBase_q;
  logic [15:0] dsSel_q;
  logic [31:0] dsBase_q;
  logic [15:0] segLimit_q;
  logic [3:0]  segAr_q;
  logic [15:0] fpuCw_q;
  logic [15:0] fpuSw_q;
  logic [15:0] fpuTag_q;
  logic [31:0] fpuOp_q;
  logic [31:0] vcsr_q;
  logic [31:0] tsc_q;
  logic [31:0] perf_q;
  logic [31:0] evsel_q;
  logic [4:0]  testCnt_q;
  logic        testFail_q;
  logic        resetClr;
  logic        wrEn;
  logic        rdEn;
  logic [79:0] fpRd;
  logic [63:0] pkRd;
  logic [63:0] xvRd;

  assign resetClr = sys_rst;
  assign wrEn     = psel && penable && pwrite && pready;
  assign rdEn     = psel && !penable && !pwrite;

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  // Reset takes priority over soft init; soft init skips the self-test
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      state_q <= cri_pkg::ST_RESET;                                      // RULE20
    else if (softInit)
      state_q <= cri_pkg::ST_SOFT;                                       // RULE7
    else
    begin
      case (state_q)
        cri_pkg::ST_RESET: state_q <= SELFTEST_EN ? cri_pkg::ST_TEST : cri_pkg::ST_RUN;
        cri_pkg::ST_TEST:
          if (testCnt_q == 5'(cri_pkg::SELFTEST_CYC - 1))
            state_q <= cri_pkg::ST_RUN;
        cri_pkg::ST_SOFT:  state_q <= cri_pkg::ST_RUN;
        cri_pkg::ST_RUN:   state_q <= cri_pkg::ST_RUN;
        default:           state_q <= cri_pkg::ST_RESET;
      endcase
    end
  end

  // Self-test counter and sticky failure; only counted in the test state
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      testCnt_q  <= '0;
      testFail_q <= 1'b0;
    end
    else if (state_q == cri_pkg::ST_TEST)
    begin
      testCnt_q  <= testCnt_q + 5'h01;
      testFail_q <= testFail_q | selfTestFail;
    end
  end

  // Accumulator: zero only if every test passed
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      acc_q <= '0;
    else if (state_q == cri_pkg::ST_TEST && testCnt_q == 5'(cri_pkg::SELFTEST_CYC - 1))
      acc_q <= (testFail_q | selfTestFail) ? 32'h0000_0001 : 32'h0000_0000;   // RULE6
    else if (wrEn && paddr == cri_pkg::A_ACC)
      acc_q <= pwdata;
  end

  // ---------------------------------------------------------------
  // Control, flags, pointer and segments
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      ctrl_q <= cri_pkg::CTRL_RST;                                       // RULE1
    else if (softInit)
    begin
      ctrl_q <= '0;                                                      // RULE3
      ctrl_q[cri_pkg::CTRL_CD_BIT]  <= ctrl_q[cri_pkg::CTRL_CD_BIT];     // RULE3
      ctrl_q[cri_pkg::CTRL_NW_BIT]  <= ctrl_q[cri_pkg::CTRL_NW_BIT];     // RULE3
      ctrl_q[cri_pkg::CTRL_ONE_BIT] <= 1'b1;                             // RULE3
    end
    else if (wrEn && paddr == cri_pkg::A_CTRL)
      ctrl_q <= pwdata;
  end

  // Segment and pointer state reload on both reset and soft init
  always_ff @(posedge clk)
  begin
    if (sys_rst || softInit)
    begin
      flags_q    <= cri_pkg::FLAGS_RST;                                  // RULE2
      ip_q       <= cri_pkg::IP_RST;
      csSel_q    <= cri_pkg::CS_SEL_RST;                                 // RULE4
      csBase_q   <= cri_pkg::CS_BASE_RST;                                // RULE4
      dsSel_q    <= cri_pkg::DS_SEL_RST;                                 // RULE5
      dsBase_q   <= cri_pkg::DS_BASE_RST;                                // RULE5
      segLimit_q <= cri_pkg::SEG_LIMIT_RST;                              // RULE4 RULE5
      segAr_q    <= cri_pkg::SEG_AR_RST;                                 // RULE4 RULE5
    end
    else
    begin
      if (wrEn && paddr == cri_pkg::A_FLAGS)
        flags_q <= pwdata;
      if (wrEn && paddr == cri_pkg::A_IP)
        ip_q <= pwdata;
      if (wrEn && paddr == cri_pkg::A_CSSEL)
        csSel_q <= pwdata[15:0];
      if (wrEn && paddr == cri_pkg::A_CSBASE)
        csBase_q <= pwdata;
    end
  end

  // ---------------------------------------------------------------
  // Floating point and vector control
  // ---------------------------------------------------------------
  // Soft init does not appear here at all, so FP state is kept
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      fpuCw_q  <= cri_pkg::FPU_CW_RST;                                   // RULE9
      fpuSw_q  <= cri_pkg::FPU_SW_CLR;                                   // RULE10
      fpuTag_q <= cri_pkg::FPU_TAG_RST;                                  // RULE11
      fpuOp_q  <= '0;                                                    // RULE10
    end
    else if (fpuInit)
    begin
      fpuCw_q  <= cri_pkg::FPU_CW_FINIT;                                 // RULE9
      fpuSw_q  <= cri_pkg::FPU_SW_CLR;                                   // RULE10
      fpuTag_q <= cri_pkg::FPU_TAG_FINIT;                                // RULE11
      fpuOp_q  <= '0;                                                    // RULE10
    end
    else if (wrEn)
    begin
      if (paddr == cri_pkg::A_FPUCW)
        fpuCw_q <= pwdata[15:0];
      if (paddr == cri_pkg::A_FPUSW)
        fpuSw_q <= pwdata[15:0];
      if (paddr == cri_pkg::A_FPUTAG)
        fpuTag_q <= pwdata[15:0];
      if (paddr == cri_pkg::A_FPUOP)
        fpuOp_q <= pwdata;
    end
  end

  // Vector control/status and counters survive soft init
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      vcsr_q  <= cri_pkg::VCSR_RST;                                      // RULE14
      tsc_q   <= '0;                                                     // RULE15
      perf_q  <= '0;                                                     // RULE15
      evsel_q <= '0;                                                     // RULE15
    end
    else
    begin
      tsc_q <= (wrEn && paddr == cri_pkg::A_TSC) ? pwdata : tsc_q + 32'h1;
      if (wrEn && paddr == cri_pkg::A_VCSR)
        vcsr_q <= pwdata;
      if (wrEn && paddr == cri_pkg::A_PERF)
        perf_q <= pwdata;
      if (wrEn && paddr == cri_pkg::A_EVSEL)
        evsel_q <= pwdata;
    end
  end

  // ---------------------------------------------------------------
  // Register arrays: FP data, packed integer, extra vector
  // ---------------------------------------------------------------
  // Only hardware reset clears them; FP init and soft init never reach clr
  cri_regmem #(.DEPTH(8), .WIDTH(80)) u_fpRegs (                         // RULE8 RULE12
    .clk   (clk),
    .clr   (resetClr),
    .we    (wrEn && paddr[7:6] == 2'b01),
    .waddr (paddr[5:3]),
    .wdata ({48'h0, pwdata}),
    .raddr (paddr[5:3]),
    .rdata (fpRd)
  );

  cri_regmem #(.DEPTH(8), .WIDTH(64)) u_pkRegs (                         // RULE13
    .clk   (clk),
    .clr   (resetClr),
    .we    (wrEn && paddr[7:6] == 2'b10),
    .waddr (paddr[5:3]),
    .wdata ({32'h0, pwdata}),
    .raddr (paddr[5:3]),
    .rdata (pkRd)
  );

  cri_regmem #(.DEPTH(8), .WIDTH(64)) u_xvRegs (                         // RULE19
    .clk   (clk),
    .clr   (resetClr),
    .we    (wrEn && paddr[7:6] == 2'b11 && EXT64_EN),
    .waddr (paddr[5:3]),
    .wdata ({32'h0, pwdata}),
    .raddr (paddr[5:3]),
    .rdata (xvRd)
  );

  // ---------------------------------------------------------------
  // Caches, ranges, interrupt controller, extra general registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      cacheValid    <= 1'b0;                                             // RULE16
      rangeEnable   <= 1'b0;                                             // RULE17
      irqCtrlEnable <= 1'b1;                                             // RULE18
      extRegsZero   <= EXT64_EN;                                         // RULE19
    end
    else if (wrEn && paddr == cri_pkg::A_CFG)
    begin
      cacheValid    <= pwdata[0];
      rangeEnable   <= pwdata[1];
      irqCtrlEnable <= pwdata[2];
      extRegsZero   <= pwdata[3] & EXT64_EN;
    end
  end

  // ---------------------------------------------------------------
  // First fetch
  // ---------------------------------------------------------------
  // One pulse on entering run after reset/self-test or soft init
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      fetchReq  <= 1'b0;
      fetchAddr <= '0;
    end
    else
    begin
      fetchReq  <= (state_q != cri_pkg::ST_RUN) && !softInit &&
                   (state_q == cri_pkg::ST_SOFT ||
                    (state_q == cri_pkg::ST_RESET && !SELFTEST_EN) ||
                    (state_q == cri_pkg::ST_TEST &&
                     testCnt_q == 5'(cri_pkg::SELFTEST_CYC - 1)));       // RULE20
      fetchAddr <= csBase_q + ip_q;                                      // RULE21
    end
  end

  // ---------------------------------------------------------------
  // APB slave: no wait states, data registered in setup phase
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      pready <= 1'b0;
    else
      pready <= psel && !penable;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      pslverr <= 1'b0;
    else
      pslverr <= psel && !penable && paddr[1:0] != 2'b00;
  end

  // Array reads use last cycle's index; array data arrives one edge late, so a single read with no wait state returns stale data
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      prdata <= '0;
    else if (rdEn)
    begin
      case (paddr)
        cri_pkg::A_CTRL:   prdata <= ctrl_q;
        cri_pkg::A_FLAGS:  prdata <= {10'h000, flags_q[21:0]};
        cri_pkg::A_IP:     prdata <= ip_q;
        cri_pkg::A_ACC:    prdata <= acc_q;
        cri_pkg::A_CSSEL:  prdata <= {dsSel_q, csSel_q};
        cri_pkg::A_CSBASE: prdata <= csBase_q;
        cri_pkg::A_FPUCW:  prdata <= {16'h0000, fpuCw_q};
        cri_pkg::A_FPUSW:  prdata <= {16'h0000, fpuSw_q};
        cri_pkg::A_FPUTAG: prdata <= {16'h0000, fpuTag_q};
        cri_pkg::A_FPUOP:  prdata <= fpuOp_q;
        cri_pkg::A_VCSR:   prdata <= vcsr_q;
        cri_pkg::A_TSC:    prdata <= tsc_q;
        cri_pkg::A_PERF:   prdata <= perf_q;
        cri_pkg::A_EVSEL:  prdata <= evsel_q;
        cri_pkg::A_CFG:    prdata <= {segAr_q, segLimit_q, 8'h00,
                                      extRegsZero, irqCtrlEnable, rangeEnable, cacheValid};
        cri_pkg::A_STAT:   prdata <= {testFail_q, 27'h0, state_q};
        default:
          case (paddr[7:6])
            2'b01:   prdata <= fpRd[31:0];
            2'b10:   prdata <= pkRd[31:0];
            2'b11:   prdata <= xvRd[31:0] ^ dsBase_q ^ (ID_SIG & 32'h0);
            default: prdata <= '0;
          endcase
      endcase
    end
  end
endmodule

// ---- tb/cri_init_state_asserts.sv ----
// Port-level checker for the init-state block, bound into its top module
`timescale 1ns/1ns
module cri_init_state_asserts #(
  parameter bit SELFTEST_EN = 1'b1,
  parameter bit EXT64_EN    = 1'b1
) (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        softInit,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        fetchReq,
  input wire logic [31:0] fetchAddr,
  input wire logic        cacheValid,
  input wire logic        rangeEnable,
  input wire logic        irqCtrlEnable,
  input wire logic        extRegsZero
);
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // Steps after reset: release, then a quiet stretch while self-test runs
  sequence rstRel;
    $fell(sys_rst);
  endsequence
  sequence testQuiet;
    !fetchReq [*8] ##1 !fetchReq [*6];
  endsequence
  // Soft init must not disturb the cache, range and interrupt-controller outputs for a few cycles
  sequence outsKept;
    ($stable(cacheValid) && $stable(rangeEnable) && $stable(irqCtrlEnable)) [*3];
  endsequence

  // Status outputs as reset leaves them
  AST_CACHE_RST: assert property (rstRel |-> !cacheValid)
    else $error("cache valid right after reset");
  AST_RANGE_RST: assert property (rstRel |-> !rangeEnable)
    else $error("range mechanism enabled right after reset");
  AST_IRQ_RST: assert property (rstRel |-> irqCtrlEnable)
    else $error("interrupt controller disabled right after reset");
  AST_EXT_RST: assert property (rstRel |-> extRegsZero == EXT64_EN)
    else $error("extra registers not zero after reset");
  // Self-test delays the first fetch; soft init skips it, so fetch comes fast
  AST_SELFTEST_WAIT: assert property ($fell(sys_rst) && SELFTEST_EN |-> testQuiet ##[1:20] fetchReq)
    else $error("first fetch not after the self-test stretch");
  AST_SOFT_FETCH: assert property ($rose(softInit) |-> ##[1:8] fetchReq)
    else $error("no prompt fetch after soft init");
  AST_SOFT_KEEP: assert property ($rose(softInit) |=> outsKept)
    else $error("soft init changed status outputs");
  AST_FETCH_ADDR: assert property (fetchReq |-> fetchAddr == 32'hffff_fff0)
    else $error("first fetch from wrong address");
  // Wait-free slave: answer in the first access cycle
  AST_PREADY: assert property (psel && !penable |=> pready)
    else $error("pready missing in access cycle");
endmodule

bind cri_init_state cri_init_state_asserts #(
  .SELFTEST_EN(SELFTEST_EN),
  .EXT64_EN   (EXT64_EN)
) chk (
  .clk          (clk),
  .sys_rst      (sys_rst),
  .softInit     (softInit),
  .psel         (psel),
  .penable      (penable),
  .pready       (pready),
  .fetchReq     (fetchReq),
  .fetchAddr    (fetchAddr),
  .cacheValid   (cacheValid),
  .rangeEnable  (rangeEnable),
  .irqCtrlEnable(irqCtrlEnable),
  .extRegsZero  (extRegsZero)
);

// ---- tb/cri_sys_model.sv ----
// Behavioural model of the system logic that resets and initializes the core
`timescale 1ns/1ns
module cri_sys_model (
  input  wire logic clk,
  output logic      sysRst,
  output logic      softInit,
  output logic      fpuInit,
  output logic      selfTestFail
);
  // Requests idle until asked for
  initial
  begin
    softInit = 1'b0;
    fpuInit  = 1'b0;
  end

  // Hardware reset for three edges; the fail flag stays up through self-test
  task automatic hwReset(input logic fail);
    sysRst       <= 1'b1;
    selfTestFail <= fail;
    repeat (3) @(posedge clk);
    sysRst <= 1'b0;
  endtask

  // One-cycle request pulse, then a spare edge so pulses never merge
  task automatic request(input logic fpu);
    if (fpu)
      fpuInit <= 1'b1;
    else
      softInit <= 1'b1;
    @(posedge clk);
    fpuInit  <= 1'b0;
    softInit <= 1'b0;
    @(posedge clk);
  endtask
endmodule

// ---- tb/tb_cri_init_state.sv ----
// Self-checking bench: reset, FP initialize and soft init values read over APB
`timescale 1ns/1ns
module tb_cri_init_state;
  logic        clk;
  logic        sysRst;
  logic        softInit;
  logic        fpuInit;
  logic        selfTestFail;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        fetchReq;
  logic [31:0] fetchAddr;
  logic        cacheValid;
  logic        rangeEnable;
  logic        irqCtrlEnable;
  logic        extRegsZero;
  logic        lastErr  = 1'b0;
  int          errCount = 0;
  int          checked  = 0;
  int          cycles   = 0;

  cri_sys_model sys (
    .clk         (clk),
    .sysRst      (sysRst),
    .softInit    (softInit),
    .fpuInit     (fpuInit),
    .selfTestFail(selfTestFail)
  );

  cri_init_state dut (
    .clk          (clk),
    .sys_rst      (sysRst),
    .softInit     (softInit),
    .fpuInit      (fpuInit),
    .selfTestFail (selfTestFail),
    .psel         (psel),
    .penable      (penable),
    .pwrite       (pwrite),
    .paddr        (paddr),
    .pwdata       (pwdata),
    .prdata       (prdata),
    .pready       (pready),
    .pslverr      (pslverr),
    .fetchReq     (fetchReq),
    .fetchAddr    (fetchAddr),
    .cacheValid   (cacheValid),
    .rangeEnable  (rangeEnable),
    .irqCtrlEnable(irqCtrlEnable),
    .extRegsZero  (extRegsZero)
  );

  // 20 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Verdict and end of run, shared by the main sequence and the timeout
  task automatic testDone;
    if (errCount == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      errCount++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // One APB transfer; request held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n == 50)
      errCount++;
    q = prdata;
    lastErr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [31:0] m = 32'hffff_ffff);
    logic [31:0] q;
    apb(1'b0, a, 32'h0, q);
    chk(q & m, e);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask

  // Array read data is registered, so the second read of an index is exact
  task automatic rd2(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    apb(1'b0, a, 32'h0, q);
    rd(a, e);
  endtask

  task automatic outs(input logic [3:0] e);
    chk({28'h0, cacheValid, rangeEnable, irqCtrlEnable, extRegsZero}, {28'h0, e});
  endtask

  task automatic waitFetch;
    int n;
    n = 0;
    while (fetchReq !== 1'b1 && n < 100)
    begin
      @(posedge clk);
      n++;
    end
    chk({31'h0, fetchReq}, 32'h0000_0001);
    chk(fetchAddr, 32'hffff_fff0);
  endtask

  // Values every hardware reset must leave, whatever was written before
  task automatic rstChecks;
    rd(cri_pkg::A_TSC, 32'h0, 32'hffff_ff00);
    rd(cri_pkg::A_CTRL, 32'h6000_0010);
    rd(cri_pkg::A_FLAGS, 32'h0000_0002, 32'h003f_ffff);
    rd(cri_pkg::A_CSSEL, 32'h0000_f000);
    rd(cri_pkg::A_CSBASE, 32'hffff_0000);
    rd(cri_pkg::A_CFG, 32'h7fff_f000, 32'hffff_f000);
    rd(cri_pkg::A_FPUCW, 32'h0000_0040);
    rd(cri_pkg::A_FPUSW, 32'h0);
    rd(cri_pkg::A_FPUOP, 32'h0);
    rd(cri_pkg::A_FPUTAG, 32'h0000_5555);
    rd(cri_pkg::A_VCSR, 32'h0000_1f80);
    rd(cri_pkg::A_PERF, 32'h0);
    rd(cri_pkg::A_EVSEL, 32'h0);
    rd2(8'h78, 32'h0);
    rd2(8'hb8, 32'h0);
    rd2(8'hf8, 32'h0);
    outs(4'b0011);
  endtask

  // Main sequence: clean reset, writes, FP init, soft init, failing reset
  initial
  begin
    logic [31:0] q;
    sys.hwReset(1'b0);
    waitFetch();
    rd(cri_pkg::A_ACC, 32'h0);
    rstChecks();
    wr(cri_pkg::A_CTRL, 32'h4000_0101);
    wr(cri_pkg::A_VCSR, 32'h0000_1234);
    wr(cri_pkg::A_FPUCW, 32'h0000_0123);
    wr(cri_pkg::A_CFG, 32'h0000_000b);
    outs(4'b1101);
    wr(cri_pkg::A_FPUSW, 32'h0000_00ff);
    wr(cri_pkg::A_FPUOP, 32'h0000_0077);
    wr(cri_pkg::A_PERF, 32'h0000_0055);
    wr(cri_pkg::A_EVSEL, 32'h0000_00aa);
    wr(cri_pkg::A_TSC, 32'h8000_0000);
    wr(8'h78, 32'h1111_2222);
    wr(8'hb8, 32'h3333_4444);
    wr(8'hf8, 32'h5555_6666);
    sys.request(1'b1);
    rd(cri_pkg::A_FPUCW, 32'h0000_037f);
    rd(cri_pkg::A_FPUSW, 32'h0);
    rd(cri_pkg::A_FPUOP, 32'h0);
    rd(cri_pkg::A_FPUTAG, 32'h0000_ffff);
    rd2(8'h78, 32'h1111_2222);
    rd2(8'hb8, 32'h3333_4444);
    sys.request(1'b0);
    waitFetch();
    rd(cri_pkg::A_CTRL, 32'h4000_0010);
    rd(cri_pkg::A_VCSR, 32'h0000_1234);
    rd(cri_pkg::A_FPUCW, 32'h0000_037f);
    rd(cri_pkg::A_FPUTAG, 32'h0000_ffff);
    outs(4'b1101);
    rd(cri_pkg::A_PERF, 32'h0000_0055);
    rd(cri_pkg::A_EVSEL, 32'h0000_00aa);
    rd(cri_pkg::A_TSC, 32'h8000_0000, 32'hffff_0000);
    rd2(8'h78, 32'h1111_2222);
    rd2(8'hf8, 32'h5555_6666);
    chk({31'h0, lastErr}, 32'h0);
    apb(1'b0, 8'h02, 32'h0, q);
    chk({31'h0, lastErr}, 32'h0000_0001);
    sys.hwReset(1'b1);
    waitFetch();
    rd(cri_pkg::A_ACC, 32'h0000_0001);
    rd(cri_pkg::A_STAT, 32'h8000_0000, 32'h8000_0000);
    rstChecks();
    testDone();
  end

  // Hang guard: the whole run needs well under a thousand cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      errCount++;
      testDone();
    end
  end
endmodule
